// [logic/ubc_defs.vh]
// Purpose: Shared constants of the USB bus state and interrupt control block.
// Assumes: Registers are 8 bits wide, each in the low byte of one 32-bit word.
// Notes: Register indices are the printed offsets; the byte address is four times the index.
`ifndef UBC_DEFS_VH
`define UBC_DEFS_VH

// ----------------------------------------------------------------------
// Register indices and byte address width
// ----------------------------------------------------------------------
`define UBC_IDX_OPER 16'hFE80
`define UBC_IDX_PORT 16'hFE81
`define UBC_IDX_IRQ 16'hFE82
`define UBC_IDX_EP0 16'hFE83
`define UBC_IDX_EP1 16'hFE84
`define UBC_IDX_LATCH 16'hFE90
`define UBC_ADDR_W 20

// ----------------------------------------------------------------------
// Reset values and bit masks
// ----------------------------------------------------------------------
`define UBC_REG_RESET 8'h00
`define UBC_OPER_RW_MASK 8'hE7
`define UBC_OPER_FLAG_MASK 8'h08
`define UBC_PORT_RW_MASK 8'hDF
`define UBC_IRQ_RW_MASK 8'h55
`define UBC_IRQ_FLAG_MASK 8'hA8
`define UBC_EP_RW_MASK 8'h55
`define UBC_EP_FLAG_MASK 8'hAA
`define UBC_ZERO8 8'h00

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define UBC_OPER_GATE 7
`define UBC_OPER_RUN 6
`define UBC_OPER_PULLA 5
`define UBC_OPER_SUSP_FG 3
`define UBC_OPER_SUSP_EN 2
`define UBC_OPER_DP_DIS 1
`define UBC_OPER_DM_DIS 0
`define UBC_PORT_FRAME_EN 7
`define UBC_PORT_PULLB 6
`define UBC_PORT_SLEEP 4
`define UBC_PORT_DP_OE 3
`define UBC_PORT_DM_OE 2
`define UBC_PORT_DP_LAT 1
`define UBC_PORT_DM_LAT 0
`define UBC_IRQ_RST_FG 7
`define UBC_IRQ_RST_EN 6
`define UBC_IRQ_ACT_FG 5
`define UBC_IRQ_ACT_EN 4
`define UBC_IRQ_SOF_FG 3
`define UBC_IRQ_SOF_EN 2
`define UBC_IRQ_EP_EN 0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define UBC_CLK_PERIOD_NS 8
`define UBC_SUSP_TIME_NS 3000000
`define UBC_RESET_TIME_NS 2500
`define UBC_PULSE_TIME_NS 80
`define UBC_SUSP_CYC ((`UBC_SUSP_TIME_NS + `UBC_CLK_PERIOD_NS - 1) / `UBC_CLK_PERIOD_NS)
`define UBC_RESET_CYC ((`UBC_RESET_TIME_NS + `UBC_CLK_PERIOD_NS - 1) / `UBC_CLK_PERIOD_NS)
`define UBC_PULSE_CYC (`UBC_PULSE_TIME_NS / `UBC_CLK_PERIOD_NS)

// ----------------------------------------------------------------------
// Bus responses
// ----------------------------------------------------------------------
`define UBC_RESP_OKAY 2'h0
`define UBC_RESP_SLVERR 2'h2

`endif

// [logic/ubc_ctrl.v]
// Purpose: Bus state detection, pin control and interrupt flags of a USB device port.
// Assumes: Pin inputs and engine events are synchronous to aclk; AXI4-Lite register access.
// Notes: Interrupt requests are levels built from flags and enables.
//
// Added by the designer: the AXI4-Lite interface to the registers.
`include "ubc_defs.vh"
`timescale 1ns/100ps
`default_nettype none

module ubc_ctrl #(
	parameter SUSP_CYC = `UBC_SUSP_CYC,
	parameter CNT_W = 20
) (
	// Clock and reset.
	input wire aclk,
	input wire aresetn,
	// AXI4-Lite write address channel.
	input wire [`UBC_ADDR_W-1:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output wire s_axi_awready,
	// AXI4-Lite write data channel.
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output wire s_axi_wready,
	// AXI4-Lite write response channel.
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// AXI4-Lite read address channel.
	input wire [`UBC_ADDR_W-1:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output wire s_axi_arready,
	// AXI4-Lite read data channel.
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// D+ and D- pins, each as input, output and active-low enable.
	input wire dplus_i,
	output wire dplus_o,
	output wire dplus_oe_n,
	input wire dminus_i,
	output wire dminus_o,
	output wire dminus_oe_n,
	// Transceiver control.
	output wire transceiver_sleep,
	output wire clock_gate_on,
	output wire full_function_run,
	// Pull-up pin A with its port latch and direction bits.
	input wire pullup_pin_a_dat,
	input wire pullup_pin_a_dir,
	output wire pullup_pin_a_o,
	output wire pullup_pin_a_oe_n,
	// Pull-up pin B with its port latch and direction bits.
	input wire pullup_pin_b_dat,
	input wire pullup_pin_b_dir,
	output wire pullup_pin_b_o,
	output wire pullup_pin_b_oe_n,
	// Frame pulse pin with its port latch and direction bits.
	input wire frame_pulse_pin_dat,
	input wire frame_pulse_pin_dir,
	output wire frame_pulse_pin_o,
	output wire frame_pulse_pin_oe_n,
	// Events from the USB protocol engine, one-cycle pulses except ep_other_irq, a level.
	input wire frame_start_seen,
	input wire [3:0] ep0_end,
	input wire [3:0] ep1_end,
	input wire ep_other_irq,
	// Interrupt requests and hold release, levels.
	output wire irq_vec_0033,
	output wire irq_vec_0013,
	output wire irq_vec_003b,
	output wire hold_release
);

	// ------------------------------------------------------------------
	// Functions
	// ------------------------------------------------------------------

	// Next value of an 8-bit register: writable bits load, flags may only be cleared.
	function [7:0] ubc_reg_next;
		input [7:0] cur;
		input wr;
		input [7:0] wd;
		input [7:0] rw_mask;
		input [7:0] flag_mask;
		input [7:0] set;
		reg [7:0] base;
		begin
			base = wr ? ((wd & rw_mask) | (cur & wd & flag_mask)) : cur;
			ubc_reg_next = base | (set & flag_mask);
		end
	endfunction

	// Any flag whose enable, the bit just below it, is also set.
	function ubc_pend;
		input [7:0] r;
		begin
			ubc_pend = |((r >> 1) & r & `UBC_EP_RW_MASK);
		end
	endfunction

	// Spread four end events onto the flag positions 7, 5, 3 and 1.
	function [7:0] ubc_spread;
		input [3:0] e;
		begin
			ubc_spread = {e[3], 1'b0, e[2], 1'b0, e[1], 1'b0, e[0], 1'b0};
		end
	endfunction

	// Register select from a byte address; zero means unmapped.
	function [2:0] ubc_decode;
		input [`UBC_ADDR_W-1:0] a;
		reg [`UBC_ADDR_W-3:0] idx;
		begin
			idx = a[`UBC_ADDR_W-1:2];
			if (a[1:0] != 2'h0)
				ubc_decode = 3'h0;
			else if (idx == `UBC_IDX_OPER)
				ubc_decode = 3'h1;
			else if (idx == `UBC_IDX_PORT)
				ubc_decode = 3'h2;
			else if (idx == `UBC_IDX_IRQ)
				ubc_decode = 3'h3;
			else if (idx == `UBC_IDX_EP0)
				ubc_decode = 3'h4;
			else if (idx == `UBC_IDX_EP1)
				ubc_decode = 3'h5;
			else if (idx == `UBC_IDX_LATCH)
				ubc_decode = 3'h6;
			else
				ubc_decode = 3'h0;
		end
	endfunction

	// ------------------------------------------------------------------
	// Registers and state
	// ------------------------------------------------------------------

	reg [7:0] oper_q; // Operation control register.
	reg [7:0] port_q; // Port control register, latch bits stored here.
	reg [7:0] irq_q; // USB interrupt control register.
	reg [7:0] ep0_q; // Endpoint 0 interrupt control register.
	reg [7:0] ep1_q; // Endpoint 1 interrupt control register.
	reg [CNT_W-1:0] idle_cnt_q; // Cycles the bus has been idle.
	reg [8:0] se0_cnt_q; // Cycles the bus has held SE0.
	reg [3:0] pulse_cnt_q; // Remaining cycles of the frame pulse.
	reg aw_full_q; // Write address held.
	reg w_full_q; // Write data held.
	reg [`UBC_ADDR_W-1:0] aw_addr_q; // Held write address.
	reg [7:0] w_data_q; // Held write byte.
	reg w_lane_q; // Low byte lane was enabled.

	localparam integer RESET_CYC = `UBC_RESET_CYC; // SE0 cycles that make a bus reset.
	localparam integer PULSE_CYC = `UBC_PULSE_CYC; // Cycles of one frame pulse.

	wire [2:0] wr_sel; // Decoded write target.
	wire wr_go; // Write commits this cycle.
	wire wr_en; // Write lands on a register.
	wire bus_idle; // Bus in J state.
	wire bus_se0; // Bus in single-ended zero.
	wire bus_active; // Bus not idle.
	wire mode_reset; // Bus reset detection enabled.
	wire mode_full; // Full function enabled.
	wire susp_hit; // Idle long enough for suspend.
	wire reset_hit; // SE0 long enough for bus reset.
	wire dp_read; // D+ as software sees it.
	wire dm_read; // D- as software sees it.
	wire [7:0] oper_set; // Hardware sets into operation control.
	wire [7:0] irq_set; // Hardware sets into interrupt control.
	wire [7:0] ep0_set; // Hardware sets into endpoint 0.
	wire [7:0] ep1_set; // Hardware sets into endpoint 1.
	wire ep_source; // Any endpoint source established.

	// ------------------------------------------------------------------
	// Bus state decode
	// ------------------------------------------------------------------

	// The full-speed idle J state has D+ high and D- low.
	assign bus_idle = dplus_i & ~dminus_i;
	assign bus_se0 = ~dplus_i & ~dminus_i;
	assign bus_active = ~bus_idle;

	assign mode_reset = oper_q[`UBC_OPER_GATE];
	assign mode_full = oper_q[`UBC_OPER_GATE] & oper_q[`UBC_OPER_RUN];
	assign clock_gate_on = oper_q[`UBC_OPER_GATE];
	assign full_function_run = mode_full;

	// ------------------------------------------------------------------
	// Duration timers
	// ------------------------------------------------------------------

	// Idle and SE0 counters saturate so that a long suspend or reset keeps
	// its flag asserted for as long as the condition lasts.
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			idle_cnt_q <= {CNT_W{1'b0}};
			se0_cnt_q <= 9'h000;
		end
		else
		begin
			// idle timer, only with full function on
			if (!bus_idle || !mode_full)
				idle_cnt_q <= {CNT_W{1'b0}};
			else if (!susp_hit)
				idle_cnt_q <= idle_cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
			if (!bus_se0 || !mode_reset)
				se0_cnt_q <= 9'h000;
			else if (!reset_hit)
				se0_cnt_q <= se0_cnt_q + 9'h001;
		end
	end

	assign susp_hit = (idle_cnt_q == SUSP_CYC[CNT_W-1:0]);
	assign reset_hit = (se0_cnt_q == RESET_CYC[8:0]);

	// ------------------------------------------------------------------
	// Frame pulse
	// ------------------------------------------------------------------

	// Each frame start with full function on reloads the counter, so a pulse never merges short.
	always @(posedge aclk)
	begin
		if (!aresetn)
			pulse_cnt_q <= 4'h0;
		else if (frame_start_seen && mode_full)
			pulse_cnt_q <= PULSE_CYC[3:0];
		else if (pulse_cnt_q != 4'h0)
			pulse_cnt_q <= pulse_cnt_q - 4'h1;
	end

	// ------------------------------------------------------------------
	// Hardware set terms
	// ------------------------------------------------------------------

	assign oper_set = {4'h0, susp_hit, 3'h0};
	// reset flag, activity flag, frame flag
	assign irq_set = {reset_hit, 1'b0, bus_active, 1'b0, frame_start_seen & mode_full, 3'h0};
	assign ep0_set = mode_full ? ubc_spread(ep0_end) : `UBC_ZERO8;
	assign ep1_set = mode_full ? ubc_spread(ep1_end) : `UBC_ZERO8;

	// ------------------------------------------------------------------
	// AXI4-Lite write path
	// ------------------------------------------------------------------

	assign s_axi_awready = ~aw_full_q & ~s_axi_bvalid;
	assign s_axi_wready = ~w_full_q & ~s_axi_bvalid;
	assign wr_go = aw_full_q & w_full_q & ~s_axi_bvalid;
	assign wr_sel = ubc_decode(aw_addr_q);
	// Reserved bits are simply not stored, so writes of one there do no harm.
	// commit lands only with the low byte lane enabled
	assign wr_en = wr_go & w_lane_q;

	// Address and data are held independently, then committed together.
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_full_q <= 1'b0;
			w_full_q <= 1'b0;
			aw_addr_q <= {`UBC_ADDR_W{1'b0}};
			w_data_q <= 8'h00;
			w_lane_q <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `UBC_RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_full_q <= 1'b1;
				aw_addr_q <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_full_q <= 1'b1;
				w_data_q <= s_axi_wdata[7:0];
				w_lane_q <= s_axi_wstrb[0];
			end
			if (wr_go)
			begin
				aw_full_q <= 1'b0;
				w_full_q <= 1'b0;
				s_axi_bvalid <= 1'b1;
				// Unmapped addresses answer with a slave error.
				s_axi_bresp <= (wr_sel == 3'h0) ? `UBC_RESP_SLVERR : `UBC_RESP_OKAY;
			end
			else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	// ------------------------------------------------------------------
	// Register file
	// ------------------------------------------------------------------

	// Flags set by hardware are cleared only by writing zero to them.
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			oper_q <= `UBC_REG_RESET;
			port_q <= `UBC_REG_RESET;
			irq_q <= `UBC_REG_RESET;
			ep0_q <= `UBC_REG_RESET;
			ep1_q <= `UBC_REG_RESET;
		end
		else
		begin
			oper_q <= ubc_reg_next(oper_q, wr_en && wr_sel == 3'h1, w_data_q,
				`UBC_OPER_RW_MASK, `UBC_OPER_FLAG_MASK, oper_set);
			port_q <= ubc_reg_next(port_q, wr_en && wr_sel == 3'h2, w_data_q,
				`UBC_PORT_RW_MASK, `UBC_ZERO8, `UBC_ZERO8);
			irq_q <= ubc_reg_next(irq_q, wr_en && wr_sel == 3'h3, w_data_q,
				`UBC_IRQ_RW_MASK, `UBC_IRQ_FLAG_MASK, irq_set);
			ep0_q <= ubc_reg_next(ep0_q, wr_en && wr_sel == 3'h4, w_data_q,
				`UBC_EP_RW_MASK, `UBC_EP_FLAG_MASK, ep0_set);
			ep1_q <= ubc_reg_next(ep1_q, wr_en && wr_sel == 3'h5, w_data_q,
				`UBC_EP_RW_MASK, `UBC_EP_FLAG_MASK, ep1_set);
		end
	end

	// ------------------------------------------------------------------
	// AXI4-Lite read path
	// ------------------------------------------------------------------

	assign dp_read = dplus_i & ~oper_q[`UBC_OPER_DP_DIS];
	assign dm_read = dminus_i & ~oper_q[`UBC_OPER_DM_DIS];

	assign s_axi_arready = ~s_axi_rvalid;

	// Read data is captured on the address handshake and held until taken.
	always @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= `UBC_RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `UBC_RESP_OKAY;
			case (ubc_decode(s_axi_araddr))
				3'h1:
					s_axi_rdata <= {24'h000000, oper_q};
				3'h2:
					s_axi_rdata <= {24'h000000, port_q[7:2], dp_read, dm_read};
				3'h3:
					s_axi_rdata <= {24'h000000, irq_q};
				3'h4:
					s_axi_rdata <= {24'h000000, ep0_q};
				3'h5:
					s_axi_rdata <= {24'h000000, ep1_q};
				3'h6:
					// Stored latch view, for read-modify-write sequences.
					s_axi_rdata <= {24'h000000, port_q};
				default:
				begin
					s_axi_rdata <= 32'h00000000;
					s_axi_rresp <= `UBC_RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rvalid && s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ------------------------------------------------------------------
	// Pins
	// ------------------------------------------------------------------

	assign dplus_o = port_q[`UBC_PORT_DP_LAT];
	assign dplus_oe_n = ~port_q[`UBC_PORT_DP_OE];
	assign dminus_o = port_q[`UBC_PORT_DM_LAT];
	assign dminus_oe_n = ~port_q[`UBC_PORT_DM_OE];

	assign transceiver_sleep = port_q[`UBC_PORT_SLEEP];

	assign pullup_pin_a_o = oper_q[`UBC_OPER_PULLA] | pullup_pin_a_dat;
	assign pullup_pin_a_oe_n = ~(oper_q[`UBC_OPER_PULLA] | pullup_pin_a_dir);

	assign pullup_pin_b_o = port_q[`UBC_PORT_PULLB] | pullup_pin_b_dat;
	assign pullup_pin_b_oe_n = ~(port_q[`UBC_PORT_PULLB] | pullup_pin_b_dir);

	// The pulse only reaches the pin when the port is an output holding zero.
	// pulse on the pin
	assign frame_pulse_pin_o = frame_pulse_pin_dat |
		(port_q[`UBC_PORT_FRAME_EN] & (pulse_cnt_q != 4'h0));
	assign frame_pulse_pin_oe_n = ~frame_pulse_pin_dir;

	// ------------------------------------------------------------------
	// Interrupt requests
	// ------------------------------------------------------------------

	assign ep_source = ubc_pend(ep0_q) | ubc_pend(ep1_q) | ep_other_irq;

	assign irq_vec_0033 = (oper_q[`UBC_OPER_SUSP_FG] & oper_q[`UBC_OPER_SUSP_EN]) |
		(irq_q[`UBC_IRQ_RST_FG] & irq_q[`UBC_IRQ_RST_EN]);
	assign irq_vec_0013 = irq_q[`UBC_IRQ_ACT_FG] & irq_q[`UBC_IRQ_ACT_EN];
	assign hold_release = irq_vec_0013;
	assign irq_vec_003b = (irq_q[`UBC_IRQ_SOF_FG] & irq_q[`UBC_IRQ_SOF_EN]) |
		(irq_q[`UBC_IRQ_EP_EN] & ep_source);

endmodule

`default_nettype wire

// [tb/ubc_ctrl_monitor.sv]
// Purpose: Port-level assertions for the USB bus state and interrupt block.
// Assumes: One clock domain; reset is synchronous and active low.
// Notes: Flags are internal, so checks tie request outputs to bus handshakes.
`timescale 1ns/100ps
`default_nettype none

module ubc_monitor #(
	parameter SUSP_CYC = 375000
) (
	// Clock and reset.
	input wire logic aclk,
	input wire logic aresetn,
	// Register bus handshakes.
	input wire logic s_axi_awready,
	input wire logic s_axi_wready,
	// Pull-up pins.
	input wire logic pullup_pin_a_dir,
	input wire logic pullup_pin_a_o,
	input wire logic pullup_pin_a_oe_n,
	input wire logic pullup_pin_b_dir,
	input wire logic pullup_pin_b_o,
	input wire logic pullup_pin_b_oe_n,
	// Frame pulse pin and event inputs.
	input wire logic frame_pulse_pin_dat,
	input wire logic frame_pulse_pin_o,
	input wire logic frame_start_seen,
	input wire logic ep_other_irq,
	// Mode and request outputs.
	input wire logic clock_gate_on,
	input wire logic full_function_run,
	input wire logic irq_vec_0033,
	input wire logic irq_vec_0013,
	input wire logic irq_vec_003b,
	input wire logic hold_release
);
	// ----------------------------------------------------------------------
	// Clocking and named steps
	// ----------------------------------------------------------------------
	default clocking mon_cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	// With both channels free no write can commit at the next edge.
	wire no_commit = s_axi_awready && s_axi_wready;
	sequence pulse_start;
		$rose(frame_pulse_pin_o) && !frame_pulse_pin_dat;
	endsequence
	sequence pulse_body;
		frame_pulse_pin_o[*8] ##1 frame_pulse_pin_o[*2] ##1 !frame_pulse_pin_o;
	endsequence

	// ----------------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------------
	a_run_needs_gate: assert property (full_function_run |-> clock_gate_on)
		else $error("Run is on without the clock gate.");
	a_pullup_a_high: assert property (!pullup_pin_a_dir && !pullup_pin_a_oe_n |-> pullup_pin_a_o)
		else $error("Pull-up pin A driven but not high.");
	a_pullup_b_high: assert property (!pullup_pin_b_dir && !pullup_pin_b_oe_n |-> pullup_pin_b_o)
		else $error("Pull-up pin B driven but not high.");
	a_pulse_cause: assert property (pulse_start |-> $past(frame_start_seen) && full_function_run)
		else $error("Frame pulse without a frame start.");
	a_pulse_width: assert property (pulse_start |-> pulse_body)
		else $error("Frame pulse is not ten cycles long.");
	a_hold_with_irq: assert property (hold_release == irq_vec_0013)
		else $error("Hold release differs from the activity request.");
	a_suspend_irq_holds: assert property (irq_vec_0033 && no_commit |=> irq_vec_0033)
		else $error("Request 0033 dropped without a write.");
	a_active_irq_holds: assert property (irq_vec_0013 && no_commit |=> irq_vec_0013)
		else $error("Request 0013 dropped without a write.");
	a_frame_irq_holds: assert property (irq_vec_003b && !ep_other_irq && no_commit |=> irq_vec_003b)
		else $error("Request 003B dropped without a write.");
endmodule

bind ubc_ctrl ubc_monitor #(.SUSP_CYC(SUSP_CYC)) mon (
	.aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready), .s_axi_wready(s_axi_wready),
	.pullup_pin_a_dir(pullup_pin_a_dir), .pullup_pin_a_o(pullup_pin_a_o),
	.pullup_pin_a_oe_n(pullup_pin_a_oe_n), .pullup_pin_b_dir(pullup_pin_b_dir),
	.pullup_pin_b_o(pullup_pin_b_o), .pullup_pin_b_oe_n(pullup_pin_b_oe_n),
	.frame_pulse_pin_dat(frame_pulse_pin_dat), .frame_pulse_pin_o(frame_pulse_pin_o),
	.frame_start_seen(frame_start_seen), .ep_other_irq(ep_other_irq),
	.clock_gate_on(clock_gate_on), .full_function_run(full_function_run),
	.irq_vec_0033(irq_vec_0033), .irq_vec_0013(irq_vec_0013),
	.irq_vec_003b(irq_vec_003b), .hold_release(hold_release)
);
`default_nettype wire

// [tb/ubc_host_model.sv]
// Purpose: Host side of the D+/D- lines, driving idle, K and SE0 states.
// Assumes: Line states change just after a rising clock edge.
// Notes: The host always drives, so the lines never float.
`timescale 1ns/100ps
`default_nettype none

module ubc_host_model (
	// Clock.
	input wire logic aclk,
	// Bus lines driven by the host.
	output var logic dp,
	output var logic dm
);
	// Idle J from time zero.
	initial {dp, dm} = 2'b10;

	// Holds one line state for n cycles.
	task send(input logic [1:0] st, input int n);
		@(posedge aclk);
		{dp, dm} <= st;
		repeat (n - 1) @(posedge aclk);
	endtask
endmodule
`default_nettype wire

// [tb/ubc_ctrl_tb.sv]
// Purpose: Register-level test of the USB bus state and interrupt block.
// Assumes: Suspend count shortened to 50 cycles.
// Notes: Expected values come from the register layout, not the design.
`include "ubc_defs.vh"
`timescale 1ns/100ps
`default_nettype none

module ubc_ctrl_tb;
	localparam [19:0] A_OPER = {`UBC_IDX_OPER, 2'b00}, A_PORT = {`UBC_IDX_PORT, 2'b00};
	localparam [19:0] A_IRQ = {`UBC_IDX_IRQ, 2'b00}, A_EP0 = {`UBC_IDX_EP0, 2'b00};
	localparam [19:0] A_LAT = {`UBC_IDX_LATCH, 2'b00}, A_BAD = 20'h3FA14;
	localparam [1:0] OK = `UBC_RESP_OKAY, BAD = `UBC_RESP_SLVERR, J = 2'b10, K = 2'b01, SE0 = 2'b00;
	// Bench-driven inputs, all valued at time zero.
	logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
	logic [19:0] awa = 0, ara = 0;
	logic [31:0] wd = 0;
	logic [3:0] ws = 4'hF, e0 = 0, e1 = 0;
	logic pa_dat = 0, pa_dir = 0, pb_dat = 0, pb_dir = 0, fp_dat = 0, fp_dir = 0, fss = 0, eo = 0;
	// Design and host model outputs.
	wire awready, wready, bvalid, arready, rvalid, dp_o, dp_oe_n, dm_o, dm_oe_n, sleep, gate, run;
	wire pa_o, pa_oe_n, pb_o, pb_oe_n, fp_o, fp_oe_n, i33, i13, i3b, hold, h_dp, h_dm;
	wire [31:0] rdata;
	wire [1:0] bresp, rresp;
	// Each data line carries the design's level while it drives, else the host's.
	wire dp_line = dp_oe_n ? h_dp : dp_o;
	wire dm_line = dm_oe_n ? h_dm : dm_o;
	int err_total = 0, total_checks = 0, i, n;

	initial
	forever #4 aclk = ~aclk;

	ubc_host_model host (.aclk(aclk), .dp(h_dp), .dm(h_dm));

	ubc_ctrl #(.SUSP_CYC(50), .CNT_W(20)) dut (
		.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awa), .s_axi_awvalid(awv),
		.s_axi_awready(awready), .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(ara), .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.dplus_i(dp_line), .dplus_o(dp_o), .dplus_oe_n(dp_oe_n), .dminus_i(dm_line),
		.dminus_o(dm_o), .dminus_oe_n(dm_oe_n), .transceiver_sleep(sleep),
		.clock_gate_on(gate), .full_function_run(run), .pullup_pin_a_dat(pa_dat),
		.pullup_pin_a_dir(pa_dir), .pullup_pin_a_o(pa_o), .pullup_pin_a_oe_n(pa_oe_n),
		.pullup_pin_b_dat(pb_dat), .pullup_pin_b_dir(pb_dir), .pullup_pin_b_o(pb_o),
		.pullup_pin_b_oe_n(pb_oe_n), .frame_pulse_pin_dat(fp_dat), .frame_pulse_pin_dir(fp_dir),
		.frame_pulse_pin_o(fp_o), .frame_pulse_pin_oe_n(fp_oe_n), .frame_start_seen(fss),
		.ep0_end(e0), .ep1_end(e1), .ep_other_irq(eo), .irq_vec_0033(i33),
		.irq_vec_0013(i13), .irq_vec_003b(i3b), .hold_release(hold)
	);

	// ----------------------------------------------------------------------
	// Checking and closing
	// ----------------------------------------------------------------------
	task chk(input [31:0] g, input [31:0] e);
		total_checks++;
		if (g !== e)
		begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, g, e);
		end
	endtask

	task final_report;
		$display("Comparisons %0d, mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// A wait that runs out ends the run as a failure.
	task tmo;
		err_total++;
		$display("Error at %0t: no bus answer", $time);
		final_report();
	endtask

	// ----------------------------------------------------------------------
	// Register bus master
	// ----------------------------------------------------------------------
	// Address and data go out together; each is dropped at its own handshake.
	task wr(input [19:0] a, input [7:0] d, input [1:0] er);
		@(posedge aclk);
		awa <= a;
		wd <= {24'h0, d};
		awv <= 1;
		wv <= 1;
		bready <= 1;
		for (n = 0; n < 20; n++)
		begin
			@(posedge aclk);
			if (awv && awready) awv <= 0;
			if (wv && wready) wv <= 0;
			if (bvalid) break;
		end
		bready <= 0;
		if (n == 20) tmo();
		chk(bresp, er);
	endtask

	task rd(input [19:0] a, input [7:0] e, input [1:0] er);
		@(posedge aclk);
		ara <= a;
		arv <= 1;
		rready <= 1;
		for (n = 0; n < 20; n++)
		begin
			@(posedge aclk);
			if (arv && arready) arv <= 0;
			if (rvalid) break;
		end
		rready <= 0;
		if (n == 20) tmo();
		chk(rdata, {24'h0, e});
		chk(rresp, er);
	endtask

	// One frame start, then the pulse cycles on the pin are counted.
	task fpulse(input [31:0] e);
		@(posedge aclk);
		fss <= 1;
		@(posedge aclk);
		fss <= 0;
		n = 0;
		repeat (14) @(posedge aclk) n += fp_o;
		chk(n, e);
	endtask

	// ----------------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------------
	initial
	begin
		repeat (4) @(posedge aclk);
		aresetn <= 1;
		// Reset values; the port read shows the idle line on D+.
		rd(A_OPER, 8'h00, OK);
		rd(A_PORT, 8'h02, OK);
		rd(A_IRQ, 8'h00, OK);
		rd(A_EP0, 8'h00, OK);
		rd(A_EP0 + 20'h4, 8'h00, OK);
		rd(A_LAT, 8'h00, OK);
		// Modes, pull-ups, input gating, general-purpose drive.
		host.send(K, 1);
		host.send(J, 1);
		wr(A_OPER, 8'hE7, OK);
		rd(A_OPER, 8'hE7, OK);
		chk({gate, run, pa_o, pa_oe_n}, 4'b1110);
		wr(A_PORT, 8'hD5, OK);
		rd(A_PORT, 8'hD4, OK);
		rd(A_LAT, 8'hD5, OK);
		chk({dp_oe_n, dm_oe_n, dm_o, sleep, pb_o, pb_oe_n}, 6'b101110);
		wr(A_OPER, 8'hE0, OK);
		rd(A_PORT, 8'hD7, OK);
		wr(A_PORT, 8'h80, OK);
		ws <= 4'h0;
		wr(A_PORT, 8'h40, OK);
		ws <= 4'hF;
		rd(A_PORT, 8'h82, OK);
		// Port's own bits pass through while pull-up B is off and no frame pulse is running.
		{pb_dat, pb_dir, fp_dat} <= 3'b011;
		@(posedge aclk);
		chk({pb_o, pb_oe_n, dp_o, fp_o, fp_oe_n}, 5'b00011);
		{pb_dat, pb_dir, fp_dat} <= 3'b000;
		rd(A_BAD, 8'h00, BAD);
		wr(A_BAD, 8'h01, BAD);
		// Activity from K and from SE0.
		for (i = 0; i < 2; i++)
		begin
			wr(A_IRQ, 8'h10, OK);
			chk({i13, hold}, 2'b00);
			host.send(i ? SE0 : K, 1);
			host.send(J, 2);
			chk({i13, hold}, 2'b11);
		end
		rd(A_IRQ, 8'h30, OK);
		wr(A_IRQ, 8'h00, OK);
		chk(i13, 0);
		// Suspend after idle, kept while idle lasts.
		wr(A_OPER, 8'hE4, OK);
		host.send(J, 60);
		chk(i33, 1);
		rd(A_OPER, 8'hEC, OK);
		wr(A_OPER, 8'hE4, OK);
		chk(i33, 1);
		host.send(K, 1);
		wr(A_OPER, 8'hE4, OK);
		chk(i33, 0);
		host.send(J, 30);
		chk(i33, 0);
		host.send(J, 30);
		chk(i33, 1);
		wr(A_OPER, 8'hE0, OK);
		// Bus reset threshold, then with the clock gate off.
		wr(A_IRQ, 8'h40, OK);
		host.send(SE0, 305);
		chk(i33, 0);
		host.send(SE0, 15);
		chk(i33, 1);
		host.send(J, 1);
		wr(A_IRQ, 8'h40, OK);
		chk(i33, 0);
		wr(A_OPER, 8'h00, OK);
		host.send(SE0, 320);
		host.send(J, 1);
		chk(i33, 0);
		rd(A_IRQ, 8'h60, OK);
		wr(A_OPER, 8'hE0, OK);
		// Frame start: flag, request, pulse, set beating clear.
		fp_dir <= 1;
		wr(A_IRQ, 8'h04, OK);
		fpulse(`UBC_PULSE_CYC);
		chk(i3b, 1);
		rd(A_IRQ, 8'h0C, OK);
		fork
			wr(A_IRQ, 8'h04, OK);
			begin
				repeat (2) @(posedge aclk);
				fss <= 1;
				@(posedge aclk);
				fss <= 0;
			end
		join
		rd(A_IRQ, 8'h0C, OK);
		wr(A_IRQ, 8'h04, OK);
		wr(A_OPER, 8'h80, OK);
		fpulse(0);
		chk(i3b, 0);
		wr(A_OPER, 8'hE0, OK);
		// Endpoint end flags, each with its own enable.
		wr(A_IRQ, 8'h01, OK);
		for (i = 0; i < 8; i++)
		begin
			wr(A_EP0 + 20'h4 * i[2], 8'h01 << 2 * i[1:0], OK);
			@(posedge aclk);
			if (i[2]) e1 <= 4'h1 << i[1:0];
			else e0 <= 4'h1 << i[1:0];
			@(posedge aclk);
			e0 <= 0;
			e1 <= 0;
			@(posedge aclk);
			chk(i3b, 1);
			rd(A_EP0 + 20'h4 * i[2], 8'h03 << 2 * i[1:0], OK);
			wr(A_EP0 + 20'h4 * i[2], 8'h01 << 2 * i[1:0], OK);
			chk(i3b, 0);
		end
		@(posedge aclk);
		eo <= 1;
		@(posedge aclk);
		chk(i3b, 1);
		wr(A_IRQ, 8'h00, OK);
		chk(i3b, 0);
		eo <= 0;
		final_report();
	end
endmodule
`default_nettype wire
